// file: usi_pkg.sv
package usi_pkg;
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_STAT     = 8'h04;
  localparam logic [7:0] ADDR_DATA     = 8'h08;
  localparam logic [7:0] ADDR_OWN      = 8'h0c;
  localparam logic [7:0] ADDR_TOC      = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;
  localparam logic [7:0] ADDR_PULL     = 8'h20;

  localparam logic [7:0] MODE_RST = 8'he0;
  localparam logic [7:0] STAT_RST = 8'h81;
  localparam logic [7:0] OWN_RST  = 8'h00;
  localparam logic [7:0] TOC_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] PULL_RST = 2'h3;

  localparam int MODE_SEL_HI = 7;
  localparam int MODE_SEL_LO = 5;
  localparam int UART_BIT    = 4;
  localparam int DEB_HI      = 3;
  localparam int DEB_LO      = 2;
  localparam int EN_BIT      = 1;
  localparam logic [2:0] OPMODE_I2C = 3'h6;

  localparam logic [1:0] DEB_SEL_NONE = 2'h0;
  localparam logic [1:0] DEB_SEL_TWO  = 2'h1;
  localparam logic [2:0] DEB_NONE     = 3'h0;
  localparam logic [2:0] DEB_TWO      = 3'h2;
  localparam logic [2:0] DEB_FOUR     = 3'h4;

  localparam int IRQ_BYTE  = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_STOP  = 2;
  localparam int IRQ_W     = 3;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT  = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_RX   = 3'h3,
    ST_TX   = 3'h2,
    ST_SKIP = 3'h6
  } usi_state_t;

  typedef struct packed {
    logic transfer_complete_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic transmit_direction_select;
    logic acknowledge_drive_control;
    logic master_read_write_flag;
    logic wake;
    logic received_acknowledge_flag;
  } usi_stat_t;

  function automatic logic [2:0] usi_deb_need(input logic [1:0] sel);
    if (sel == DEB_SEL_NONE) begin
      return DEB_NONE;
    end else if (sel == DEB_SEL_TWO) begin
      return DEB_TWO;
    end else begin
      return DEB_FOUR;
    end
  endfunction : usi_deb_need
endpackage : usi_pkg

// file: usi_i2c_slave.sv
// Design decisions made here: the APB slave port and the register addresses.
module usi_i2c_slave (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             scl_pull_en,
  output logic             sda_pull_en,
  output logic             irq
);
  logic [7:0]              mode_reg;
  usi_pkg::usi_stat_t      stat;
  logic [7:0]              shift_data;
  logic [7:0]              own_addr;
  logic [7:0]              toc;
  logic [1:0]              pull;
  logic [usi_pkg::IRQ_W-1:0] irq_stat;
  logic [usi_pkg::IRQ_W-1:0] irq_en;
  logic [1:0]              scl_sync;
  logic [1:0]              sda_sync;
  logic                    scl_f;
  logic                    scl_prev;
  logic                    sda_prev;
  logic [2:0]              deb_cnt;
  usi_pkg::usi_state_t     state;
  logic [3:0]              bitcnt;
  logic [7:0]              shreg;
  logic                    ack_drive;
  logic                    en_prev;

  logic [7:0]              next_mode_reg;
  usi_pkg::usi_stat_t      next_stat;
  logic [7:0]              next_shift_data;
  logic [7:0]              next_own_addr;
  logic [7:0]              next_toc;
  logic [1:0]              next_pull;
  logic [usi_pkg::IRQ_W-1:0] next_irq_stat;
  logic [usi_pkg::IRQ_W-1:0] next_irq_en;
  logic                    next_scl_f;
  logic [2:0]              next_deb_cnt;
  usi_pkg::usi_state_t     next_state;
  logic [3:0]              next_bitcnt;
  logic [7:0]              next_shreg;
  logic                    next_ack_drive;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;

  logic                    i2c_mode;
  logic                    enable;
  logic                    active;
  logic [2:0]              deb_need;
  logic                    scl_s;
  logic                    sda_s;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  logic                    wr;
  logic                    setup;
  logic [7:0]              rd_value;
  logic                    mapped;
  logic [usi_pkg::IRQ_W-1:0] ev;

  // second stage only is read by logic
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];

  assign i2c_mode = !mode_reg[usi_pkg::UART_BIT] &&
                    mode_reg[usi_pkg::MODE_SEL_HI:usi_pkg::MODE_SEL_LO] == usi_pkg::OPMODE_I2C;
  assign enable   = mode_reg[usi_pkg::EN_BIT];
  assign active   = i2c_mode && enable;
  // debounce only counts in i2c mode
  assign deb_need = i2c_mode ?
                    usi_pkg::usi_deb_need(mode_reg[usi_pkg::DEB_HI:usi_pkg::DEB_LO]) :
                    usi_pkg::DEB_NONE;

  assign scl_rise  = scl_f && !scl_prev;
  assign scl_fall  = !scl_f && scl_prev;
  assign start_det = scl_f && scl_prev && sda_prev && !sda_s;
  assign stop_det  = scl_f && scl_prev && !sda_prev && sda_s;

  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign pready = penable;

  // open drain: the pin value is always low, only the enable moves
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // hold scl low after a byte until software services the data register
  assign scl_oe  = active && stat.transfer_complete_flag && bitcnt == 4'h0 && !scl_f &&
                   (state == usi_pkg::ST_RX || state == usi_pkg::ST_TX);
  assign sda_oe  = active && (ack_drive ||
                   (state == usi_pkg::ST_TX && bitcnt < usi_pkg::BYTE_BITS &&
                    !stat.transfer_complete_flag && !shreg[7]));
  assign scl_pull_en = pull[0];
  assign sda_pull_en = pull[1];
  assign irq = |(irq_stat & irq_en);

  always_comb begin
    // own address decodes where spi control lives in spi mode
    mapped   = 1'b1;
    rd_value = 8'h00;
    if (paddr == usi_pkg::ADDR_MODE) begin
      rd_value = mode_reg;
    end else if (paddr == usi_pkg::ADDR_STAT) begin
      rd_value = i2c_mode ? stat : 8'h00;
    end else if (paddr == usi_pkg::ADDR_DATA) begin
      rd_value = shift_data;
    end else if (paddr == usi_pkg::ADDR_OWN) begin
      rd_value = i2c_mode ? own_addr : 8'h00;
    end else if (paddr == usi_pkg::ADDR_TOC) begin
      rd_value = i2c_mode ? toc : 8'h00;
    end else if (paddr == usi_pkg::ADDR_IRQ_STAT) begin
      rd_value = {5'h00, irq_stat};
    end else if (paddr == usi_pkg::ADDR_IRQ_CLR) begin
      rd_value = 8'h00;
    end else if (paddr == usi_pkg::ADDR_IRQ_EN) begin
      rd_value = {5'h00, irq_en};
    end else if (paddr == usi_pkg::ADDR_PULL) begin
      rd_value = {6'h00, pull};
    end else begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    next_mode_reg   = mode_reg;
    next_stat       = stat;
    next_shift_data = shift_data;
    next_own_addr   = own_addr;
    next_toc        = toc;
    next_pull       = pull;
    next_irq_en     = irq_en;
    next_scl_f      = scl_f;
    next_deb_cnt    = deb_cnt;
    next_state      = state;
    next_bitcnt     = bitcnt;
    next_shreg      = shreg;
    next_ack_drive  = ack_drive;
    next_prdata     = prdata;
    next_pslverr    = pslverr;
    ev              = '0;

    // read data is captured in setup so the answer comes from flops
    if (setup) begin
      next_prdata  = {24'h000000, rd_value};
      next_pslverr = !mapped;
    end

    // scl must stay at a new level deb_need+1 samples to be taken
    if (scl_s == scl_f) begin
      next_deb_cnt = 3'h0;
    end else if (deb_cnt >= deb_need) begin
      next_scl_f   = scl_s;
      next_deb_cnt = 3'h0;
    end else begin
      next_deb_cnt = deb_cnt + 3'h1;
    end

    // software writes; clears of hcf come before hardware sets
    if (wr && mapped) begin
      if (paddr == usi_pkg::ADDR_MODE) begin
        next_mode_reg = pwdata[7:0];
      end else if (paddr == usi_pkg::ADDR_STAT && i2c_mode) begin
        next_stat.transmit_direction_select  = pwdata[4];
        next_stat.acknowledge_drive_control = pwdata[3];
        next_stat.wake = pwdata[1];
      end else if (paddr == usi_pkg::ADDR_DATA) begin
        next_shift_data = pwdata[7:0];
        if (i2c_mode) begin
          next_stat.transfer_complete_flag = 1'b0;
        end
        if (state == usi_pkg::ST_TX && stat.transfer_complete_flag) begin
          next_shreg = pwdata[7:0];
        end
      end else if (paddr == usi_pkg::ADDR_OWN && i2c_mode) begin
        next_own_addr = pwdata[7:0];
      end else if (paddr == usi_pkg::ADDR_TOC && i2c_mode) begin
        next_toc = pwdata[7:0];
      end else if (paddr == usi_pkg::ADDR_IRQ_EN) begin
        next_irq_en = pwdata[usi_pkg::IRQ_W-1:0];
      end else if (paddr == usi_pkg::ADDR_PULL) begin
        next_pull = pwdata[1:0];
      end
    end
    // reading a received byte also releases the stretch
    if (psel && penable && !pwrite && paddr == usi_pkg::ADDR_DATA && i2c_mode) begin
      next_stat.transfer_complete_flag = 1'b0;
    end

    if (!active) begin
      next_state     = usi_pkg::ST_IDLE;
      next_bitcnt    = 4'h0;
      next_ack_drive = 1'b0;
      next_stat.bus_busy_flag  = 1'b0;
    end else if (start_det) begin
      next_state     = usi_pkg::ST_ADDR;
      next_bitcnt    = 4'h0;
      next_ack_drive = 1'b0;
      next_stat.bus_busy_flag  = 1'b1;
      next_stat.address_match_flag = 1'b0;
    end else if (stop_det) begin
      next_state     = usi_pkg::ST_IDLE;
      next_bitcnt    = 4'h0;
      next_ack_drive = 1'b0;
      next_stat.bus_busy_flag  = 1'b0;
      next_stat.address_match_flag = 1'b0;
      ev[usi_pkg::IRQ_STOP] = 1'b1;
    end else if (state != usi_pkg::ST_IDLE && state != usi_pkg::ST_SKIP) begin
      if (scl_rise) begin
        if (bitcnt < usi_pkg::BYTE_BITS) begin
          if (state != usi_pkg::ST_TX) begin
            next_shreg = {shreg[6:0], sda_s};
          end
          next_bitcnt = bitcnt + 4'h1;
        end else if (bitcnt == usi_pkg::BYTE_BITS) begin
          next_bitcnt = usi_pkg::ACK_SLOT;
          if (state == usi_pkg::ST_TX) begin
            next_stat.received_acknowledge_flag = sda_s;
          end
        end
      end else if (scl_fall) begin
        if (bitcnt == usi_pkg::BYTE_BITS) begin
          case (state)
            usi_pkg::ST_ADDR: begin
              if (shreg[7:1] == own_addr[7:1]) begin
                next_stat.address_match_flag = 1'b1;
                next_stat.master_read_write_flag  = shreg[0];
                next_ack_drive = 1'b1;
                ev[usi_pkg::IRQ_MATCH] = 1'b1;
              end else begin
                next_state = usi_pkg::ST_SKIP;
              end
            end
            usi_pkg::ST_RX: begin
              next_shift_data = shreg;
              next_ack_drive  = !stat.acknowledge_drive_control;
            end
            default: begin
              next_ack_drive = 1'b0;
            end
          endcase
        end else if (bitcnt == usi_pkg::ACK_SLOT) begin
          next_ack_drive = 1'b0;
          next_bitcnt    = 4'h0;
          next_stat.transfer_complete_flag  = 1'b1;
          ev[usi_pkg::IRQ_BYTE] = 1'b1;
          if (state == usi_pkg::ST_ADDR) begin
            next_state = stat.master_read_write_flag ? usi_pkg::ST_TX : usi_pkg::ST_RX;
          end else if (state == usi_pkg::ST_TX && stat.received_acknowledge_flag) begin
            // master refused more data: leave the bus alone until stop or a repeated start
            next_state = usi_pkg::ST_SKIP;
          end
        end else if (state == usi_pkg::ST_TX && bitcnt != 4'h0) begin
          next_shreg = {shreg[6:0], 1'b0};
        end
      end
    end

    // flags return to defaults when the interface is switched on
    if (enable && !en_prev) begin
      next_stat.transfer_complete_flag  = 1'b1;
      next_stat.address_match_flag = 1'b0;
      next_stat.bus_busy_flag  = 1'b0;
      next_stat.master_read_write_flag  = 1'b0;
      next_stat.received_acknowledge_flag = 1'b1;
    end

    // a set in the clear cycle survives
    next_irq_stat = (irq_stat & ~((wr && paddr == usi_pkg::ADDR_IRQ_CLR) ?
                    pwdata[usi_pkg::IRQ_W-1:0] : '0)) | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= usi_pkg::MODE_RST;
      stat       <= usi_pkg::STAT_RST;
      shift_data <= usi_pkg::DATA_RST;
      own_addr   <= usi_pkg::OWN_RST;
      toc        <= usi_pkg::TOC_RST;
      pull       <= usi_pkg::PULL_RST;
      irq_stat   <= '0;
      irq_en     <= '0;
      scl_sync   <= 2'h3;
      sda_sync   <= 2'h3;
      scl_f      <= 1'b1;
      scl_prev   <= 1'b1;
      sda_prev   <= 1'b1;
      deb_cnt    <= 3'h0;
      state      <= usi_pkg::ST_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      ack_drive  <= 1'b0;
      en_prev    <= 1'b0;
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
    end else begin
      mode_reg   <= next_mode_reg;
      stat       <= next_stat;
      shift_data <= next_shift_data;
      own_addr   <= next_own_addr;
      toc        <= next_toc;
      pull       <= next_pull;
      irq_stat   <= next_irq_stat;
      irq_en     <= next_irq_en;
      scl_sync   <= {scl_sync[0], scl_in};
      sda_sync   <= {sda_sync[0], sda_in};
      scl_f      <= next_scl_f;
      scl_prev   <= scl_f;
      sda_prev   <= sda_s;
      deb_cnt    <= next_deb_cnt;
      state      <= next_state;
      bitcnt     <= next_bitcnt;
      shreg      <= next_shreg;
      ack_drive  <= next_ack_drive;
      en_prev    <= enable;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start;
    active && start_det;
  endsequence
  sequence s_busy_open;
    stat.bus_busy_flag && state == usi_pkg::ST_ADDR && bitcnt == 4'h0;
  endsequence

  property p_off_released;
    !enable |-> !scl_oe && !sda_oe;
  endproperty
  a_off_released: assert property (p_off_released) else $error("pins driven while off");

  property p_drive_only_i2c;
    (scl_oe || sda_oe) |-> !mode_reg[4] && mode_reg[7:5] == 3'h6;
  endproperty
  a_drive_only_i2c: assert property (p_drive_only_i2c) else $error("pins driven outside i2c");

  property p_deb_two;
    i2c_mode && mode_reg[3:2] == 2'h1 && $stable(mode_reg) && $changed(scl_f) |->
      $past(scl_s, 1) == scl_f && $past(scl_s, 2) == scl_f && $past(scl_s, 3) == scl_f;
  endproperty
  a_deb_two: assert property (p_deb_two) else $error("scl passed debounce too soon");

  property p_no_deb_outside;
    !i2c_mode && $changed(scl_s) |=> scl_f == $past(scl_s);
  endproperty
  a_no_deb_outside: assert property (p_no_deb_outside) else $error("debounce outside i2c");

  property p_addr_match;
    $rose(stat.address_match_flag) |-> $past(shreg[7:1]) == own_addr[7:1] && sda_oe;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("match without address");

  property p_rx_to_data;
    state == usi_pkg::ST_RX && scl_fall && bitcnt == 4'h8 && !start_det && !stop_det
      |=> shift_data == $past(shreg);
  endproperty
  a_rx_to_data: assert property (p_rx_to_data) else $error("byte not stored");

  property p_enable_defaults;
    $rose(enable) |=> stat.transfer_complete_flag && !stat.address_match_flag && !stat.bus_busy_flag && !stat.master_read_write_flag && stat.received_acknowledge_flag &&
      stat.transmit_direction_select == $past(stat.transmit_direction_select) && stat.acknowledge_drive_control == $past(stat.acknowledge_drive_control);
  endproperty
  a_enable_defaults: assert property (p_enable_defaults) else $error("flags not reset");

  property p_start_busy;
    s_start |=> s_busy_open;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");

  property p_stat_hidden;
    setup && paddr == usi_pkg::ADDR_STAT && !i2c_mode |=> prdata == 32'h00000000;
  endproperty
  a_stat_hidden: assert property (p_stat_hidden) else $error("status seen outside i2c");
endmodule : usi_i2c_slave

// file: usi_i2c_master_model.sv
module usi_i2c_master_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      stall_err
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_low   = 1'b0;
    sda_low   = 1'b0;
    stall_err = 1'b0;
  end
  // only pull low or release, pull-ups make the high level
  task automatic scl_release();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n >= 4000) begin
      stall_err = 1'b1;
    end
    #120;
  endtask : scl_release
  // data changes late in the low phase, after the slave has seen the fall
  task automatic bit_io(input logic b, output logic s);
    #180;
    sda_low = ~b;
    #20;
    scl_release();
    s = sda;
    scl_low = 1'b1;
  endtask : bit_io
  task automatic start_cond();
    sda_low = 1'b1;
    #160;
    scl_low = 1'b1;
  endtask : start_cond
  task automatic stop_cond();
    #180;
    sda_low = 1'b1;
    #20;
    scl_release();
    sda_low = 1'b0;
    #300;
  endtask : stop_cond
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
    // slave needs a few clocks to see the ninth fall before the bench looks
    #400;
  endtask : write_byte
  task automatic read_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, s);
    #400;
  endtask : read_byte
endmodule : usi_i2c_master_model

// file: tb_usi_i2c_slave.sv
module tb_usi_i2c_slave;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq;
  logic        scl_out, scl_oe, sda_out, sda_oe, scl_pull_en, sda_pull_en;
  logic        m_scl_low, m_sda_low, stall_err;
  wire         scl = ~(scl_oe & ~scl_out) & ~m_scl_low;
  wire         sda = ~(sda_oe & ~sda_out) & ~m_sda_low;
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        err, ack;
  logic [7:0]  rb;
  // 25 mhz is above every minimum system clock for these bus rates
  always #20 pclk = ~pclk;
  usi_i2c_slave usi_i2c_slave_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_pull_en(scl_pull_en), .sda_pull_en(sda_pull_en), .irq(irq));
  usi_i2c_master_model usi_i2c_master_model_i (
    .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low), .stall_err(stall_err));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    // callers may come from the link side at any time: launch on an edge
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    n = 0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd & m);
  endtask : rchk
  task automatic frame(input logic [7:0] a, input logic e);
    usi_i2c_master_model_i.start_cond();
    usi_i2c_master_model_i.write_byte(a, ack);
    chk("ack", {31'h0, e}, {31'h0, ack});
    usi_i2c_master_model_i.stop_cond();
  endtask : frame
  always @(posedge stall_err) begin
    miscompares++;
    final_report();
  end
  initial begin
    #3ms;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(usi_pkg::ADDR_MODE, 32'hffffffff, 32'he0);
    rchk(usi_pkg::ADDR_PULL, 32'hffffffff, 32'h3);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // spi master with debounce bits set: no answer, scl passes unfiltered
    apb(1'b1, usi_pkg::ADDR_MODE, 32'h0e);
    frame(8'ha4, 1'b0);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, usi_pkg::ADDR_MODE, {24'h0, c[2:0], 5'h00});
      apb(1'b1, usi_pkg::ADDR_OWN, 32'h5a);
      rchk(usi_pkg::ADDR_OWN, 32'hff, (c == 6) ? 32'h5a : 32'h0);
      rchk(usi_pkg::ADDR_STAT, 32'hff, (c == 6) ? {24'h0, usi_pkg::STAT_RST} : 32'h0);
    end
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hd0);
    apb(1'b1, usi_pkg::ADDR_OWN, 32'h33);
    rchk(usi_pkg::ADDR_OWN, 32'hff, 32'h0);
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hc2);
    rchk(usi_pkg::ADDR_STAT, 32'hff, 32'h81);
    apb(1'b1, usi_pkg::ADDR_OWN, 32'ha5);
    rchk(usi_pkg::ADDR_OWN, 32'hff, 32'ha5);
    apb(1'b1, usi_pkg::ADDR_PULL, 32'h0);
    chk("pulls", 32'h0, {30'h0, scl_pull_en, sda_pull_en});
    apb(1'b1, usi_pkg::ADDR_PULL, 32'h3);
    apb(1'b1, usi_pkg::ADDR_IRQ_EN, 32'h7);
    usi_i2c_master_model_i.start_cond();
    usi_i2c_master_model_i.write_byte(8'ha4, ack);
    chk("addr ack", 32'h1, {31'h0, ack});
    chk("irq", 32'h1, {31'h0, irq});
    chk("stretch", 32'h1, {31'h0, scl_oe});
    rchk(usi_pkg::ADDR_IRQ_STAT, 32'h3, 32'h3);
    rchk(usi_pkg::ADDR_STAT, 32'hfe, 32'he0);
    rchk(usi_pkg::ADDR_DATA, 32'hff, {24'h0, usi_pkg::DATA_RST});
    usi_i2c_master_model_i.write_byte(8'h3c, ack);
    chk("data ack", 32'h1, {31'h0, ack});
    rchk(usi_pkg::ADDR_DATA, 32'hffffffff, 32'h3c);
    usi_i2c_master_model_i.stop_cond();
    rchk(usi_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4);
    rchk(usi_pkg::ADDR_STAT, 32'h20, 32'h0);
    apb(1'b1, usi_pkg::ADDR_IRQ_CLR, 32'h7);
    chk("irq cleared", 32'h0, {31'h0, irq});
    frame(8'h22, 1'b0);
    apb(1'b1, usi_pkg::ADDR_IRQ_CLR, 32'h7);
    apb(1'b1, usi_pkg::ADDR_IRQ_EN, 32'h0);
    usi_i2c_master_model_i.start_cond();
    usi_i2c_master_model_i.write_byte(8'ha5, ack);
    chk("read ack", 32'h1, {31'h0, ack});
    rchk(usi_pkg::ADDR_STAT, 32'hfe, 32'he4);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, usi_pkg::ADDR_DATA, 32'ha3);
    usi_i2c_master_model_i.read_byte(1'b0, rb);
    chk("tx byte", 32'ha3, {24'h0, rb});
    rchk(usi_pkg::ADDR_DATA, 32'hff, 32'ha3);
    usi_i2c_master_model_i.stop_cond();
    apb(1'b1, usi_pkg::ADDR_IRQ_EN, 32'h7);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, usi_pkg::ADDR_IRQ_CLR, 32'h7);
    // scl high phase is three clocks, shorter than a four clock filter
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hca);
    frame(8'ha4, 1'b0);
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hce);
    frame(8'ha4, 1'b0);
    // a two clock filter lets the three clock high phase through
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hc6);
    usi_i2c_master_model_i.start_cond();
    usi_i2c_master_model_i.write_byte(8'ha4, ack);
    chk("deb two ack", 32'h1, {31'h0, ack});
    rchk(usi_pkg::ADDR_DATA, 32'hff, 32'ha3);
    usi_i2c_master_model_i.stop_cond();
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hc0);
    chk("oe off", 32'h0, {30'h0, scl_oe, sda_oe});
    frame(8'ha4, 1'b0);
    apb(1'b1, usi_pkg::ADDR_STAT, 32'h18);
    apb(1'b1, usi_pkg::ADDR_MODE, 32'hc2);
    rchk(usi_pkg::ADDR_STAT, 32'hff, 32'h99);
    final_report();
  end
endmodule : tb_usi_i2c_slave
